// ===== include/adc_seq_defs.svh
// Offsets, field positions, reset values and timing for the converter sequencer
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// Register indices; the byte address is four times the index
`define IDX_RESULT_1       14'h1031
`define IDX_RESULT_2       14'h1032
`define IDX_RESULT_3       14'h1033
`define IDX_RESULT_4       14'h1034
`define IDX_SYS_OPTIONS    14'h1039
`define IDX_CONV_CONTROL   14'h1030
`define IDX_IRQ_STATUS     14'h1040
`define IDX_IRQ_MASK       14'h1041

// Converter control fields
`define CTL_DONE_BIT       7
`define CTL_SCAN_BIT       5
`define CTL_MULTI_CHANNEL_SELECT_BIT       4
`define CTL_CH_HI          3
`define CTL_CH_LO          0
`define CTL_GROUP_HI       3
`define CTL_GROUP_LO       2

// System options fields and reset value
`define OPT_POWER_BIT      7
`define OPT_CLKSEL_BIT     6
`define OPT_RESET          8'h10

// Interrupt status bit for a finished sequence
`define IRQ_DONE_BIT       0

// Sequence timing, counted in bus clocks
`define SAMPLE_CYCLES      12
`define SCAN_PERIOD_NS     64000
`define REF_BUS_KHZ        2000
`define CONV_PER_SEQ       4
`define CONV_CYCLES        (`SCAN_PERIOD_NS * `REF_BUS_KHZ / 1000000 / `CONV_PER_SEQ)

`endif

// ===== include/adc_seq_pkg.sv
// Types shared by the converter sequencer
package adc_seq_pkg;

    // Sequencer phases
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } seq_state_t;

    // Request towards the analog front end
    typedef struct packed {
        logic       sample_enable;
        logic       convert_active;
        logic       rc_clock_select;
        logic       power_up;
        logic [3:0] channel;
    } analog_req_t;

    // Finished conversion waiting for a bus-idle cycle
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [1:0] slot;
        logic [7:0] data;
    } pending_result_t;

endpackage : adc_seq_pkg

// ===== core/adc_sequence_control.sv
// Converter sequencer with Wishbone register slave and done interrupt
// Functional notes
// RULE1: Control register governs all converter operation
// RULE2: Four readable 8-bit result registers
// RULE3: Results update only while no read happens
// RULE4: Clock-select bit picks bus or RC clock
// RULE5: Software picks RC clock below 750 kHz
// RULE6: Sequences of four, single or continuous
// RULE7: Done flag set after fourth conversion
// RULE8: Sequence timing counted on bus clock
// RULE9: Scan clear: four conversions then stop
// RULE10: Scan set: convert forever, update results
// RULE11: Single channel: four conversions of one
// RULE12: Multi channel: four channels, one each
// RULE13: Multi: upper two bits pick group
// RULE14: Low code bits map to result slot
// RULE15: Codes for references; others reserved
// RULE16: Input connected only during 12-cycle sample
// RULE17: Scan period fixes cycles per conversion
// RULE18: Control write aborts, clears flag, restarts
// RULE19: Reserved codes run, results undefined
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_sequence_control #(
    parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES,
    parameter int CONV_CYCLES   = `CONV_CYCLES
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [15:0]                adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic      [31:0]                dat_o,
    output logic                            ack_o,
    input  wire logic [7:0]                 conv_data_i,
    output var  adc_seq_pkg::analog_req_t   analog_o,
    output logic                            irq_o
);

    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYCLES - 1);
    localparam logic [4:0] CONV_LAST   = 5'(CONV_CYCLES - 1);

    adc_seq_pkg::seq_state_t      state_q;
    adc_seq_pkg::pending_result_t pend_q;
    logic [4:0]  cycle_q;
    logic [1:0]  slot_q;
    logic        done_flag_q;
    logic        scan_q;
    logic        multi_channel_select_q;
    logic [3:0]  chan_q;
    logic [7:0]  options_q;
    logic        irq_stat_q;
    logic        irq_mask_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [7:0]  data_s1_q;
    logic [7:0]  data_s2_q;
    logic [7:0]  result_q [4];
    logic [13:0] reg_idx;
    logic        bus_req;
    logic        bus_wr;
    logic        ctl_wr;
    logic        opt_wr;
    logic        stat_wr;
    logic        mask_wr;
    logic        conv_end;
    logic        commit;
    logic        seq_done;
    logic [7:0]  rd_byte;
    logic [3:0]  cur_chan;

    // Bus decode; writes take effect on the edge that sees ack
    assign reg_idx = adr_i[15:2];
    assign bus_req = cyc_i & stb_i;
    assign bus_wr  = bus_req & we_i & ack_q & sel_i[0];
    // RULE1: control reached by write
    assign ctl_wr  = bus_wr & (reg_idx == `IDX_CONV_CONTROL);
    assign opt_wr  = bus_wr & (reg_idx == `IDX_SYS_OPTIONS);
    assign stat_wr = bus_wr & (reg_idx == `IDX_IRQ_STATUS);
    assign mask_wr = bus_wr & (reg_idx == `IDX_IRQ_MASK);

    // Acknowledge one cycle after the request, drop the cycle after
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            ack_q <= 1'b0;
        else
            ack_q <= bus_req & ~ack_q;
    end

    // Read mux; unmapped indices read as zero
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (reg_idx)
            `IDX_RESULT_1:     rd_byte = result_q[0];
            `IDX_RESULT_2:     rd_byte = result_q[1];
            `IDX_RESULT_3:     rd_byte = result_q[2];
            `IDX_RESULT_4:     rd_byte = result_q[3];
            `IDX_SYS_OPTIONS:  rd_byte = options_q;
            `IDX_CONV_CONTROL: rd_byte = {done_flag_q, 1'b0, scan_q, multi_channel_select_q, chan_q};
            `IDX_IRQ_STATUS:   rd_byte = {7'h00, irq_stat_q};
            `IDX_IRQ_MASK:     rd_byte = {7'h00, irq_mask_q};
            default:           rd_byte = 8'h00;
        endcase
    end

    // Read data captured as ack rises and held while it stands
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            rdata_q <= 32'h0000_0000;
        else if (bus_req & ~ack_q)
            rdata_q <= {24'h00_0000, rd_byte};
    end

    assign dat_o = rdata_q;
    assign ack_o = ack_q;

    // RULE1: control fields stored on write
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            scan_q <= 1'b0;
            multi_channel_select_q <= 1'b0;
            chan_q <= 4'h0;
        end
        else if (ctl_wr)
        begin
            scan_q <= dat_i[`CTL_SCAN_BIT];
            multi_channel_select_q <= dat_i[`CTL_MULTI_CHANNEL_SELECT_BIT];
            chan_q <= dat_i[`CTL_CH_HI:`CTL_CH_LO];
        end
    end

    // RULE4: options hold the clock select
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            options_q <= `OPT_RESET;
        else if (opt_wr)
            options_q <= dat_i[7:0];
    end

    // Two-flop capture of the front end result; held stable at conversion end
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end
        else
        begin
            data_s1_q <= conv_data_i;
            data_s2_q <= data_s1_q;
        end
    end

    assign conv_end = (state_q == adc_seq_pkg::ST_CONVERT) & (cycle_q == CONV_LAST);

    // RULE8: phases counted in bus clocks
    // RULE6: four conversions per pass
    // RULE18: write aborts and restarts
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= adc_seq_pkg::ST_IDLE;
            cycle_q <= 5'h00;
            slot_q  <= 2'h0;
        end
        else if (ctl_wr)
        begin
            state_q <= adc_seq_pkg::ST_SAMPLE;
            cycle_q <= 5'h00;
            slot_q  <= 2'h0;
        end
        else
        begin
            unique case (state_q)
                adc_seq_pkg::ST_IDLE:
                begin
                    cycle_q <= 5'h00;
                end
                // RULE16: sample window length
                adc_seq_pkg::ST_SAMPLE:
                begin
                    cycle_q <= cycle_q + 5'h01;
                    if (cycle_q == SAMPLE_LAST)
                        state_q <= adc_seq_pkg::ST_CONVERT;
                end
                // RULE17: fixed cycles per conversion
                adc_seq_pkg::ST_CONVERT:
                begin
                    cycle_q <= cycle_q + 5'h01;
                    if (conv_end)
                    begin
                        cycle_q <= 5'h00;
                        slot_q  <= slot_q + 2'h1;
                        // RULE9: stop after one pass
                        // RULE10: rerun when scanning
                        if (slot_q == 2'h3 && !scan_q)
                            state_q <= adc_seq_pkg::ST_IDLE;
                        else
                            state_q <= adc_seq_pkg::ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    // RULE11: single channel repeats code
    // RULE13: group from upper bits
    // RULE12: slot picks the channel
    // RULE15: reference codes pass through
    // RULE19: reserved codes run anyway
    assign cur_chan = multi_channel_select_q ? {chan_q[`CTL_GROUP_HI:`CTL_GROUP_LO], slot_q} : chan_q;

    // Front end request; switch closed only while sampling
    always_comb
    begin
        analog_o.sample_enable   = (state_q == adc_seq_pkg::ST_SAMPLE);
        analog_o.convert_active  = (state_q == adc_seq_pkg::ST_CONVERT);
        analog_o.rc_clock_select = options_q[`OPT_CLKSEL_BIT];
        analog_o.power_up        = options_q[`OPT_POWER_BIT];
        analog_o.channel         = cur_chan;
    end

    // RULE3: park result until bus idle
    assign commit = pend_q.valid & ~bus_req;
    assign seq_done = commit & pend_q.last;

    // Pending result; a write to control drops a half-done sequence
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            pend_q <= '0;
        else if (ctl_wr)
            pend_q <= '0;
        else if (conv_end)
        begin
            pend_q.valid <= 1'b1;
            pend_q.last  <= (slot_q == 2'h3);
            pend_q.slot  <= slot_q;
            pend_q.data  <= data_s2_q;
        end
        else if (commit)
            pend_q.valid <= 1'b0;
    end

    // RULE2: four result registers
    // RULE14: slot selects the register
    for (genvar g = 0; g < 4; g++)
    begin : g_result
        always_ff @(posedge ref_clk or posedge reset)
        begin
            if (reset)
                result_q[g] <= 8'h00;
            else if (commit && pend_q.slot == 2'(g))
                result_q[g] <= pend_q.data;
        end
    end

    // RULE7: flag once fourth result lands
    // RULE18: control write clears the flag
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            done_flag_q <= 1'b0;
        else if (ctl_wr)
            done_flag_q <= 1'b0;
        else if (seq_done)
            done_flag_q <= 1'b1;
    end

    // Sticky interrupt status; a new event beats a write-one clear
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            irq_stat_q <= 1'b0;
        else if (seq_done)
            irq_stat_q <= 1'b1;
        else if (stat_wr && dat_i[`IRQ_DONE_BIT])
            irq_stat_q <= 1'b0;
    end

    // Interrupt mask
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            irq_mask_q <= 1'b0;
        else if (mask_wr)
            irq_mask_q <= dat_i[`IRQ_DONE_BIT];
    end

    assign irq_o = irq_stat_q & irq_mask_q;

    // Helper counters for the checks below
    logic [4:0] samp_run_q;
    logic [5:0] conv_len_q;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            samp_run_q <= 5'h00;
        else if (analog_o.sample_enable && !ctl_wr)
            samp_run_q <= samp_run_q + 5'h01;
        else
            samp_run_q <= 5'h00;
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            conv_len_q <= 6'h00;
        else if (ctl_wr || conv_end || state_q == adc_seq_pkg::ST_IDLE)
            conv_len_q <= 6'h00;
        else
            conv_len_q <= conv_len_q + 6'h01;
    end

    property p_ack_answer;
        @(posedge ref_clk) disable iff (reset)
        bus_req && !ack_q |=> ack_q ##1 !ack_q;
    endproperty
    a_ack_answer: assert property (p_ack_answer) // RULE1
        else $error("ack did not follow the request by one cycle");

    property p_commit_idle;
        @(posedge ref_clk) disable iff (reset)
        bus_req |=> $stable(result_q[0]) && $stable(result_q[1]) && $stable(result_q[2]) &&
            $stable(result_q[3]);
    endproperty
    a_commit_idle: assert property (p_commit_idle) // RULE3
        else $error("result register changed during a bus access");

    property p_clock_select;
        @(posedge ref_clk) disable iff (reset)
        opt_wr |=> analog_o.rc_clock_select == $past(dat_i[`OPT_CLKSEL_BIT]);
    endproperty
    a_clock_select: assert property (p_clock_select) // RULE4
        else $error("clock select did not follow the options write");

    property p_flag_after_four;
        @(posedge ref_clk) disable iff (reset)
        $rose(done_flag_q) |-> $past(pend_q.last) && $past(pend_q.slot) == 2'h3;
    endproperty
    a_flag_after_four: assert property (p_flag_after_four) // RULE7
        else $error("done flag rose without the fourth result");

    property p_single_stops;
        @(posedge ref_clk) disable iff (reset)
        conv_end && slot_q == 2'h3 && !scan_q && !ctl_wr |=> state_q == adc_seq_pkg::ST_IDLE;
    endproperty
    a_single_stops: assert property (p_single_stops) // RULE9
        else $error("single pass did not stop after four conversions");

    property p_scan_restarts;
        @(posedge ref_clk) disable iff (reset)
        conv_end && scan_q |=> analog_o.sample_enable && cycle_q == 5'h00;
    endproperty
    a_scan_restarts: assert property (p_scan_restarts) // RULE10
        else $error("scan mode did not start the next conversion");

    property p_single_channel;
        @(posedge ref_clk) disable iff (reset)
        analog_o.sample_enable && !multi_channel_select_q |-> analog_o.channel == chan_q;
    endproperty
    a_single_channel: assert property (p_single_channel) // RULE11
        else $error("single channel mode drove the wrong channel");

    property p_multi_channel;
        @(posedge ref_clk) disable iff (reset)
        analog_o.sample_enable && multi_channel_select_q |-> analog_o.channel == {chan_q[3:2], slot_q};
    endproperty
    a_multi_channel: assert property (p_multi_channel) // RULE13
        else $error("multi channel mode drove the wrong channel");

    property p_sample_len;
        @(posedge ref_clk) disable iff (reset)
        $fell(analog_o.sample_enable) && !$past(ctl_wr) |->
            samp_run_q == 5'(SAMPLE_CYCLES);
    endproperty
    a_sample_len: assert property (p_sample_len) // RULE16
        else $error("sample window was not twelve cycles");

    property p_conv_len;
        @(posedge ref_clk) disable iff (reset)
        conv_end && !ctl_wr |-> conv_len_q == 6'(CONV_CYCLES - 1);
    endproperty
    a_conv_len: assert property (p_conv_len) // RULE17
        else $error("conversion length differs from the scan period");

    property p_write_restart;
        @(posedge ref_clk) disable iff (reset)
        ctl_wr |=> !done_flag_q && state_q == adc_seq_pkg::ST_SAMPLE && slot_q == 2'h0;
    endproperty
    a_write_restart: assert property (p_write_restart) // RULE18
        else $error("control write did not restart the sequence");

endmodule : adc_sequence_control
`default_nettype wire

// ===== bench/analog_front_model.sv
// Behavioural model of the analog multiplexer and comparator side
`timescale 1ns/10ps
`default_nettype none

module analog_front_model (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire adc_seq_pkg::analog_req_t  req,
    output logic [7:0]                     data
);
    logic [7:0] noise_q;

    // Free-running pattern between conversions; it steps through every 8-bit value, valid-looking codes included
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            noise_q <= 8'h00;
        else
            noise_q <= noise_q + 8'h35;
    end

    // channel code encoded in data
    // Result held for the whole approximation phase, as the sequencer needs
    assign data = req.convert_active ? {req.channel, ~req.channel} : noise_q;
endmodule : analog_front_model

`default_nettype wire

// ===== bench/adc_sequence_control_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_defs.svh"

module adc_sequence_control_tb;
    logic                     ref_clk = 1'b0;
    logic                     reset   = 1'b1;
    logic                     cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [15:0]              adr = 16'h0000;
    logic [3:0]               sel = 4'h0;
    logic [31:0]              wdat = 32'h0, rdat;
    logic                     ack, irq;
    logic [7:0]               conv_data;
    adc_seq_pkg::analog_req_t analog;
    int errors = 0, n_tests = 0, cycles = 0, n_conv = 0, se_len = 0, se_last = 0;

    adc_sequence_control adc_sequence_control_inst (.ref_clk(ref_clk), .reset(reset),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .conv_data_i(conv_data), .analog_o(analog),
        .irq_o(irq));
    analog_front_model analog_front_model_inst (.ref_clk(ref_clk), .reset(reset),
        .req(analog), .data(conv_data));

    // Bus clock, 25 ns period
    // bus clock above threshold
    always #12.5 ref_clk = ~ref_clk;

    // Count conversions and measure the sample window length
    always @(posedge ref_clk)
    begin
        cycles++;
        if (analog.sample_enable === 1'b1)
            se_len++;
        else if (se_len != 0)
        begin
            // A finished window leads into a conversion; an aborted one merges
            se_last = se_len;
            se_len = 0;
            n_conv++;
        end
        // Hang guard: whole run needs well under this
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One classic Wishbone cycle; waits for ack without a bound
    task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d,
                      output logic [31:0] rd);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (ack !== 1'b1);
        check(n, 2);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    function automatic logic [31:0] res_of(input logic [3:0] ch);
        return {24'h0, ch, ~ch};
    endfunction : res_of

    // Start a sequence, wait for done, compare the four results unless the group bits are 2'b10
    task automatic run_seq(input logic [7:0] ctl, input logic [3:0] ch0, input logic step);
        logic [31:0] rd;
        int n, c0;
        wb(1'b1, `IDX_CONV_CONTROL, ctl, rd);
        wb(1'b0, `IDX_CONV_CONTROL, 8'h00, rd);
        check(rd, {24'h0, 2'b00, ctl[5:0]});
        // Counted from here so a scan aborted by the write adds nothing
        c0 = n_conv;
        n = 0;
        do
        begin
            wb(1'b0, `IDX_CONV_CONTROL, 8'h00, rd);
            n++;
        end
        while (rd[7] !== 1'b1 && n < 200);
        check(rd[7], 1'b1);
        check(se_last, 12);
        for (int k = 0; k < 4; k++)
        begin
            wb(1'b0, 14'(`IDX_RESULT_1 + k), 8'h00, rd);
            if (ctl[3:2] != 2'b10)
                check(rd, res_of(ch0 + 4'(k * step)));
        end
        if (!ctl[5])
        begin
            repeat (40) @(posedge ref_clk);
            check(n_conv - c0, 4);
        end
    endtask : run_seq

    // Interrupt raise, mask and clear around a finished sequence
    task automatic irq_test();
        logic [31:0] rd;
        wb(1'b1, `IDX_IRQ_MASK, 8'h01, rd);
        wb(1'b1, `IDX_IRQ_STATUS, 8'h01, rd);
        // Let the write settle before looking at the level output
        @(negedge ref_clk);
        check(irq, 1'b0);
        run_seq(8'h02, 4'h2, 1'b0);
        check(irq, 1'b1);
        wb(1'b1, `IDX_IRQ_MASK, 8'h00, rd);
        @(negedge ref_clk);
        check(irq, 1'b0);
        wb(1'b0, `IDX_IRQ_STATUS, 8'h00, rd);
        check(rd[0], 1'b1);
        wb(1'b1, `IDX_IRQ_STATUS, 8'h01, rd);
        wb(1'b1, `IDX_IRQ_MASK, 8'h01, rd);
        @(negedge ref_clk);
        check(irq, 1'b0);
    endtask : irq_test

    // Registers after reset, clock select and power-up, unmapped place
    task automatic reg_test();
        logic [31:0] rd;
        wb(1'b0, `IDX_SYS_OPTIONS, 8'h00, rd);
        check(rd, 32'h10);
        wb(1'b0, `IDX_RESULT_1, 8'h00, rd);
        check(rd, 32'h0);
        wb(1'b1, `IDX_SYS_OPTIONS, 8'hc0, rd);
        wb(1'b0, `IDX_SYS_OPTIONS, 8'h00, rd);
        check(rd, 32'hc0);
        check({analog.rc_clock_select, analog.power_up}, 2'b11);
        wb(1'b0, 14'h1050, 8'h00, rd);
        check(rd, 32'h0);
    endtask : reg_test

    // Continuous scan keeps going; a control write aborts it
    task automatic scan_test();
        logic [31:0] rd;
        int c;
        run_seq(8'h34, 4'h4, 1'b1);
        c = n_conv;
        repeat (70) @(posedge ref_clk);
        check(n_conv - c >= 2, 1'b1);
        run_seq(8'h31, 4'h0, 1'b1);
        run_seq(8'h07, 4'h7, 1'b0);
        wb(1'b1, `IDX_RESULT_1, 8'hff, rd);
        wb(1'b0, `IDX_RESULT_1, 8'h00, rd);
        check(rd, res_of(4'h7));
    endtask : scan_test

    initial
    begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        reg_test();
        run_seq(8'h05, 4'h5, 1'b0);
        run_seq(8'h17, 4'h4, 1'b1);
        run_seq(8'h1c, 4'hc, 1'b1);
        run_seq(8'h18, 4'h8, 1'b1);
        scan_test();
        irq_test();
        give_verdict();
    end
endmodule : adc_sequence_control_tb

`default_nettype wire
